// ### clock_stop_idle_control.sv
// Added by the designer: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
// Functional notes
// RULE1: internal clock is oscillator divided by two or one
// RULE2: crystal users must choose divide by two
// RULE3: writing one to bit 7 enters stop
// RULE4: stop halts oscillator, clock low, phase one high
// RULE5: stop ends on reset or 4 ms wake pin high; the code takes the pin only with bit 5 set
// RULE6: oscillator gets 4 ms to settle after stop
// RULE7: oscillator restarts on rise, timing on fall
// RULE8: idle freezes clock low, oscillator keeps running
// RULE9: bit 6 with bit 4 or 5 enters idle
// RULE10: wake pin falling edge ends idle when enabled
// RULE11: falling port d wake OR ends idle when enabled
// RULE12: reset clears stop and idle requests
module clock_stop_idle_control
    import clock_mode_pkg::*;
#(
    parameter logic DIV_BY_TWO = 1'b1,
    parameter int unsigned WAKE_HOLD = WAKE_HOLD_CYCLES,
    parameter int unsigned OSC_STAB = OSC_STAB_CYCLES
) (
    input wire logic core_clk,                 // oscillator reference clock
    input wire logic rst_n,                    // async reset, active low
    input wire logic [ADDR_W-1:0] avs_address, // byte address
    input wire logic avs_read,                 // read request
    input wire logic avs_write,                // write request
    input wire logic [31:0] avs_writedata,     // write data
    input wire logic [3:0] avs_byteenable,     // byte lanes
    output logic [31:0] avs_readdata,          // read data
    output logic avs_waitrequest,              // stall while high
    input wire logic external_wake_pin,        // wake pin, async
    input wire logic port_d_wake_input_a,      // port d wake a, async
    input wire logic port_d_wake_input_b,      // port d wake b, async
    output logic osc_enable,                   // oscillator running
    output logic proc_clk,                     // internal processor clock
    output logic phase_one_clock,              // complement of proc_clk
    output logic proc_tick                     // one pulse per proc_clk rise; held high with proc_clk in divide by one
);

    // the wake wait covers both the hold time and oscillator settling
    localparam int unsigned WAKE_NEED = (WAKE_HOLD > OSC_STAB) ? WAKE_HOLD : OSC_STAB;
    localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_NEED - 1);

    clk_core_state_t q;
    clk_core_state_t d;

    logic [2:0] pins_async;
    logic [2:0] pins_sync;
    logic wake_pin_s;
    logic port_d_or_s;
    logic bus_req;
    logic take;
    logic ctrl_hit;
    logic status_hit;
    logic pin_fall;
    logic port_d_fall;

    assign pins_async = {port_d_wake_input_b, port_d_wake_input_a, external_wake_pin};

    pin_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin_in(pins_async),
        .pin_out(pins_sync)
    );

    assign wake_pin_s = pins_sync[0];
    assign port_d_or_s = pins_sync[1] | pins_sync[2];

    // a request is accepted in its first cycle and answered in the next
    assign bus_req = avs_read | avs_write;
    assign take = bus_req & ~q.ack;
    assign ctrl_hit = (avs_address == BUS_CTRL_OFFSET);
    assign status_hit = (avs_address == MODE_STATUS_OFFSET);

    assign pin_fall = q.pin_prev & ~wake_pin_s;
    assign port_d_fall = q.port_d_prev & ~port_d_or_s;

    function automatic logic idle_armed(input logic [7:0] ctrl);
        idle_armed = ctrl[IDLE_REQ_POS]
            & (ctrl[PIN_WAKE_EN_POS] | ctrl[PORT_D_WAKE_EN_POS]);
    endfunction

    function automatic logic [31:0] status_word(input clk_core_state_t s);
        logic [31:0] w;
        w = READ_ZERO;
        w[ST_MODE_LSB +: 3] = s.mode;
        w[ST_OSC_RUN_POS] = s.osc_run;
        w[ST_CLK_RUN_POS] = (s.mode == MODE_RUN);
        w[ST_WOKE_PIN_POS] = s.woke_pin;
        w[ST_WOKE_PORT_D_POS] = s.woke_port_d;
        w[ST_DIV_TWO_POS] = DIV_BY_TWO;
        status_word = w;
    endfunction

    function automatic logic [7:0] clear_mode_req(input logic [7:0] ctrl);
        logic [7:0] c;
        c = ctrl;
        c[STOP_REQ_POS] = 1'b0;
        c[IDLE_REQ_POS] = 1'b0;
        clear_mode_req = c;
    endfunction

    always_comb begin
        d = q;
        d.tick = 1'b0;
        d.ack = take;
        d.pin_prev = wake_pin_s;
        d.port_d_prev = port_d_or_s;

        // register bus
        if (take && avs_write && ctrl_hit && avs_byteenable[0]) begin
            d.bus_ctrl = avs_writedata[7:0];
        end
        if (take && avs_write && status_hit && avs_byteenable[0]) begin
            // writing the status register clears the wake cause flags
            d.woke_pin = 1'b0;
            d.woke_port_d = 1'b0;
        end
        if (take && avs_read) begin
            if (ctrl_hit) begin
                d.rdata = {24'h00_0000, q.bus_ctrl};
            end else if (status_hit) begin
                d.rdata = status_word(q);
            end else begin
                d.rdata = READ_ZERO;
            end
        end

        // mode sequencing
        unique case (q.mode)
            MODE_RUN: begin
                d.osc_run = 1'b1;
                d.cnt = '0;
                if (q.bus_ctrl[STOP_REQ_POS]) begin
                    d.mode = MODE_STOP; // [RULE3]
                    d.osc_run = 1'b0; // [RULE4]
                end else if (idle_armed(q.bus_ctrl)) begin
                    d.mode = MODE_IDLE; // [RULE9]
                end else if (q.bus_ctrl[IDLE_REQ_POS]) begin
                    // idle with no wake source enabled would never end
                    d.bus_ctrl = clear_mode_req(q.bus_ctrl);
                end
            end
            MODE_IDLE: begin
                d.osc_run = 1'b1; // [RULE8]
                if (q.bus_ctrl[PIN_WAKE_EN_POS] && pin_fall) begin
                    d.mode = MODE_RUN; // [RULE10]
                    d.woke_pin = 1'b1;
                    d.bus_ctrl = clear_mode_req(d.bus_ctrl);
                end
                if (q.bus_ctrl[PORT_D_WAKE_EN_POS] && port_d_fall) begin
                    d.mode = MODE_RUN; // [RULE11]
                    d.woke_port_d = 1'b1;
                    d.bus_ctrl = clear_mode_req(d.bus_ctrl);
                end
            end
            MODE_STOP: begin
                d.osc_run = 1'b0; // [RULE4]
                d.cnt = '0;
                if (q.bus_ctrl[PIN_WAKE_EN_POS] && wake_pin_s) begin
                    d.mode = MODE_WAKE_HIGH;
                    d.osc_run = 1'b1; // [RULE7]
                end
            end
            MODE_WAKE_HIGH: begin
                d.osc_run = 1'b1;
                if (!wake_pin_s) begin
                    // pin dropped before the hold time: stay stopped
                    d.mode = MODE_STOP; // [RULE5]
                    d.osc_run = 1'b0;
                    d.cnt = '0;
                end else if (q.cnt == WAKE_LAST) begin
                    d.mode = MODE_WAKE_FALL; // [RULE5] [RULE6]
                end else begin
                    d.cnt = q.cnt + CNT_W'(1);
                end
            end
            MODE_WAKE_FALL: begin
                d.osc_run = 1'b1;
                if (!wake_pin_s) begin
                    d.mode = MODE_RUN; // [RULE7]
                    d.woke_pin = 1'b1;
                    d.bus_ctrl = clear_mode_req(d.bus_ctrl);
                end
            end
            default: begin
                d.mode = MODE_RUN;
                d.osc_run = 1'b1;
                d.cnt = '0;
            end
        endcase

        // internal clock generation, frozen low outside run; follows the next mode
        // so the clock is already low on the edge that drops the oscillator
        if (d.mode == MODE_RUN) begin
            if (DIV_BY_TWO) begin
                d.div = ~q.div; // [RULE1]
                d.proc_clk = ~q.div;
                d.tick = ~q.div;
            end else begin
                // divide by one: the core clock itself, gated by proc_tick
                d.div = 1'b0; // [RULE1]
                d.proc_clk = 1'b1;
                d.tick = 1'b1;
            end
        end else begin
            d.div = 1'b0;
            d.proc_clk = 1'b0; // [RULE4] [RULE8]
        end
        d.phase_one = ~d.proc_clk; // [RULE4]
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q.mode <= MODE_RUN; // [RULE12]
            q.bus_ctrl <= BUS_CTRL_RESET; // [RULE12]
            q.cnt <= '0;
            q.div <= 1'b0;
            q.proc_clk <= 1'b0;
            q.phase_one <= 1'b1;
            q.tick <= 1'b0;
            q.osc_run <= 1'b1; // [RULE5] [RULE12]
            q.woke_pin <= 1'b0;
            q.woke_port_d <= 1'b0;
            q.ack <= 1'b0;
            q.rdata <= READ_ZERO;
            q.pin_prev <= 1'b0;
            q.port_d_prev <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign avs_waitrequest = bus_req & ~q.ack;
    assign avs_readdata = q.rdata;
    assign osc_enable = q.osc_run;
    assign proc_clk = q.proc_clk;
    assign phase_one_clock = q.phase_one;
    assign proc_tick = q.tick;

endmodule

// ### clock_mode_pkg.sv
package clock_mode_pkg;

    // register map, byte addresses on the Avalon-MM slave
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] BUS_CTRL_OFFSET = 4'h0;
    localparam logic [ADDR_W-1:0] MODE_STATUS_OFFSET = 4'h4;

    // bus control register field positions
    localparam int STOP_REQ_POS = 7;
    localparam int IDLE_REQ_POS = 6;
    localparam int PIN_WAKE_EN_POS = 5;
    localparam int PORT_D_WAKE_EN_POS = 4;
    localparam logic [7:0] BUS_CTRL_RESET = 8'h00;

    // mode status register field positions
    localparam int ST_MODE_LSB = 0;
    localparam int ST_OSC_RUN_POS = 3;
    localparam int ST_CLK_RUN_POS = 4;
    localparam int ST_WOKE_PIN_POS = 5;
    localparam int ST_WOKE_PORT_D_POS = 6;
    localparam int ST_DIV_TWO_POS = 7;

    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // timing
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned WAKE_HOLD_MS = 4;
    localparam int unsigned OSC_STAB_MS = 4;
    localparam int unsigned WAKE_HOLD_CYCLES = WAKE_HOLD_MS * (CLK_HZ / MS_PER_S);
    localparam int unsigned OSC_STAB_CYCLES = OSC_STAB_MS * (CLK_HZ / MS_PER_S);
    localparam int CNT_W = 24;

    typedef enum logic [2:0] {
        MODE_RUN = 3'b000,
        MODE_IDLE = 3'b001,
        MODE_STOP = 3'b010,
        MODE_WAKE_HIGH = 3'b011,
        MODE_WAKE_FALL = 3'b100
    } clk_mode_t;

    typedef struct packed {
        clk_mode_t mode;
        logic [7:0] bus_ctrl;
        logic [CNT_W-1:0] cnt;
        logic div;
        logic proc_clk;
        logic phase_one;
        logic tick;
        logic osc_run;
        logic woke_pin;
        logic woke_port_d;
        logic ack;
        logic [31:0] rdata;
        logic pin_prev;
        logic port_d_prev;
    } clk_core_state_t;

endpackage

// ### pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,            // core clock
    input wire logic rst_n,               // async reset, active low
    input wire logic [WIDTH-1:0] pin_in,  // asynchronous pin levels
    output logic [WIDTH-1:0] pin_out      // levels after two flops
);
    // state: stage one in the low half, stage two in the high half
    logic [2*WIDTH-1:0] sync_q;
    logic [2*WIDTH-1:0] sync_d;

    always_comb begin
        sync_d = {sync_q[WIDTH-1:0], pin_in};
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_q <= '0;
        end else begin
            sync_q <= sync_d;
        end
    end

    // only the second stage leaves this module
    assign pin_out = sync_q[2*WIDTH-1:WIDTH];
endmodule

// ### clock_stop_idle_control_properties.sv
`timescale 1ns/1ps
module clock_stop_idle_control_checker
    import clock_mode_pkg::*;
#(
    parameter logic DIV_BY_TWO = 1'b1,
    parameter int unsigned OSC_STAB = 20
) (
    input wire logic core_clk, // clock
    input wire logic rst_n, // reset, active low
    input wire logic [ADDR_W-1:0] avs_address, // address
    input wire logic avs_read, // read
    input wire logic avs_write, // write
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // lanes
    input wire logic avs_waitrequest, // stall
    input wire logic external_wake_pin, // wake pin
    input wire logic osc_enable, // oscillator on
    input wire logic proc_clk, // internal clock
    input wire logic phase_one_clock, // its complement
    input wire logic proc_tick // internal clock rise
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // cycles of running oscillator, and whether the wake pin was seen low since it started
    int unsigned stab_q;
    logic seen_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stab_q <= OSC_STAB;
            seen_q <= 1'b1;
        end else if (!osc_enable) begin
            stab_q <= 0;
            seen_q <= 1'b0;
        end else begin
            stab_q <= (stab_q < OSC_STAB) ? stab_q + 1 : stab_q;
            seen_q <= seen_q | !external_wake_pin;
        end
    end
    sequence s_ctrl_wr;
        avs_write && avs_waitrequest && avs_address == BUS_CTRL_OFFSET && avs_byteenable[0];
    endsequence
    sequence s_frozen;
        (osc_enable && !proc_clk && !proc_tick) [*3];
    endsequence
    property p_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_wait: assert property (p_wait) else $error("no answer");
    property p_phase; phase_one_clock == !proc_clk; endproperty
    a_phase: assert property (p_phase) else $error("phase one wrong");
    property p_frozen; !osc_enable |-> !proc_clk && !proc_tick; endproperty
    a_frozen: assert property (p_frozen) else $error("clock runs in stop");
    property p_div; DIV_BY_TWO && proc_tick |=> !proc_tick; endproperty
    a_div: assert property (p_div) else $error("divide wrong");
    property p_stop; s_ctrl_wr ##0 avs_writedata[7] |-> ##[2:4] !osc_enable; endproperty
    a_stop: assert property (p_stop) else $error("stop not entered");
    property p_idle;
        s_ctrl_wr ##0 (avs_writedata[7:6] == 2'b01 && |avs_writedata[5:4]) |-> ##[2:4] s_frozen;
    endproperty
    a_idle: assert property (p_idle) else $error("idle not entered");
    property p_stab; proc_tick |-> stab_q >= OSC_STAB; endproperty
    a_stab: assert property (p_stab) else $error("settle time short");
    property p_fall; proc_tick |-> seen_q; endproperty
    a_fall: assert property (p_fall) else $error("timing before pin fall");
    property p_reset; $rose(rst_n) |-> osc_enable ##[1:4] proc_tick; endproperty
    a_reset: assert property (p_reset) else $error("not running after reset");
endmodule
bind clock_stop_idle_control clock_stop_idle_control_checker #(.DIV_BY_TWO(DIV_BY_TWO),
    .OSC_STAB(OSC_STAB)) clock_stop_idle_control_checker_i (.core_clk, .rst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest,
    .external_wake_pin, .osc_enable, .proc_clk, .phase_one_clock, .proc_tick);

// ### wake_source_model.sv
`timescale 1ns/1ps
module wake_source_model #(
    parameter int unsigned HOLD = 20
) (
    input wire logic core_clk, // clock
    input wire logic wake_go, // start a long wake pulse
    input wire logic pin_lvl, // level set by the bench
    output logic external_wake_pin // to the block
);
    int unsigned cnt_q = 0;
    // pin held past the hold time, then dropped so timing restarts
    always_ff @(posedge core_clk) begin
        if (wake_go) begin
            cnt_q <= HOLD + 8;
        end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
        end
    end
    assign external_wake_pin = (cnt_q != 0) || pin_lvl;
endmodule

// ### test_clock_stop_idle_control.sv
`timescale 1ns/1ps
module test_clock_stop_idle_control
    import clock_mode_pkg::*;
;
    localparam logic [3:0] BC = BUS_CTRL_OFFSET;
    localparam logic [3:0] MS = MODE_STATUS_OFFSET;
    logic core_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h0;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
    logic avs_waitrequest, osc_enable, proc_clk, phase_one_clock, proc_tick, external_wake_pin;
    logic pd_a = 1'b0, pd_b = 1'b0, pin_lvl = 1'b0, wake_go = 1'b0;
    int error_cnt = 0, n_tests = 0;
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    // divide by two, as a crystal source requires
    clock_stop_idle_control #(.DIV_BY_TWO(1'b1), .WAKE_HOLD(20), .OSC_STAB(20))
        clock_stop_idle_control_i (.core_clk, .rst_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .external_wake_pin,
        .port_d_wake_input_a(pd_a), .port_d_wake_input_b(pd_b), .osc_enable, .proc_clk,
        .phase_one_clock, .proc_tick);
    wake_source_model #(.HOLD(20)) wake_source_model_i (.core_clk, .wake_go, .pin_lvl,
        .external_wake_pin);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] d,
        input logic [3:0] be, input logic [31:0] exp);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        if (!wr) chk(avs_readdata, exp);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wait_tick(input int n);
        for (int i = 0; i < n && proc_tick !== 1'b1; i++) @(posedge core_clk);
        chk(32'(proc_tick), 32'h0000_0001);
    endtask
    task automatic do_reset;
        rst_n <= 1'b0;
        cyc(5);
        rst_n <= 1'b1;
        cyc(1);
    endtask
    task automatic pulse_wake;
        wake_go <= 1'b1;
        cyc(1);
        wake_go <= 1'b0;
    endtask
    task automatic t_reset_state;
        bus(MS, 1'b0, 0, 4'hf, 32'h0000_0098);
        bus(BC, 1'b1, 32'h0000_0080, 4'h0, 0);
        bus(BC, 1'b0, 0, 4'hf, 32'h0000_0000);
        bus(4'h8, 1'b0, 0, 4'hf, 32'h0000_0000);
        bus(BC, 1'b1, 32'h0000_0040, 4'h1, 0);
        cyc(3);
        wait_tick(4);
        bus(BC, 1'b0, 0, 4'hf, 32'h0000_0000);
    endtask
    task automatic t_stop_pin;
        bus(BC, 1'b1, 32'h0000_00a0, 4'h1, 0);
        cyc(4);
        chk(32'({osc_enable, proc_clk, phase_one_clock}), 32'h0000_0001);
        pin_lvl <= 1'b1;
        cyc(5);
        pin_lvl <= 1'b0;
        cyc(10);
        chk(32'({osc_enable, proc_tick}), 32'h0000_0000);
        pulse_wake();
        wait_tick(100);
        bus(MS, 1'b0, 0, 4'hf, 32'h0000_00b8);
        bus(BC, 1'b0, 0, 4'hf, 32'h0000_0020);
    endtask
    task automatic t_stop_locked;
        bus(BC, 1'b1, 32'h0000_0080, 4'h1, 0);
        pulse_wake();
        cyc(60);
        chk(32'(osc_enable), 32'h0000_0000);
        do_reset();
        bus(BC, 1'b0, 0, 4'hf, 32'h0000_0000);
        wait_tick(4);
    endtask
    task automatic t_idle(input logic [7:0] ctrl, input logic by_pin);
        pin_lvl <= 1'b1;
        pd_a <= 1'b1;
        pd_b <= 1'b1;
        bus(MS, 1'b1, 0, 4'h1, 0);
        bus(BC, 1'b1, {24'h00_0000, ctrl}, 4'h1, 0);
        cyc(4);
        chk(32'({osc_enable, proc_clk, proc_tick}), 32'h0000_0004);
        pd_a <= 1'b0;
        cyc(6);
        chk(32'(proc_tick), 32'h0000_0000);
        if (by_pin) begin
            pin_lvl <= 1'b0;
        end else begin
            pd_b <= 1'b0;
        end
        wait_tick(12);
        bus(MS, 1'b0, 0, 4'hf, by_pin ? 32'h0000_00b8 : 32'h0000_00d8);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        do_reset();
        t_reset_state();
        t_stop_pin();
        t_stop_locked();
        t_idle(8'h50, 1'b0);
        t_idle(8'h60, 1'b1);
        t_idle(8'h70, 1'b1);
        t_idle(8'h70, 1'b0);
        tally_and_finish();
    end
    // the whole sequence needs well under a thousand cycles
    initial begin
        cyc(5000);
        error_cnt++;
        tally_and_finish();
    end
endmodule
